// *** core/aec_core.sv ***
// access capture registers and arithmetic trap logic
`timescale 1ns/1ps
`default_nettype none
module aec_core (
  input  wire logic               clk_i,           // processor clock
  input  wire logic               rst_i,           // sync reset, high
  input  wire logic [31:0]        wb_adr_i,        // byte address
  input  wire logic [31:0]        wb_dat_i,        // write data
  output logic      [31:0]        wb_dat_o,        // read data
  input  wire logic               wb_cyc_i,        // cycle
  input  wire logic               wb_stb_i,        // strobe
  input  wire logic               wb_we_i,         // write enable
  input  wire logic [3:0]         wb_sel_i,        // byte lanes
  output logic                    wb_ack_o,        // acknowledge
  input  wire aec_pkg::aec_access_t acc_i,         // access being started
  input  wire logic               trap_take_i,     // interrupt or trap taken
  input  wire logic               target_write_i,  // later instr wrote reg
  input  wire logic [7:0]         target_reg_i,    // its register number
  input  wire logic               interrupt_return_i,          // interrupt return pulse
  input  wire logic [31:0]        instr_addr_i,    // arith instruction address
  input  wire aec_pkg::aec_arith_t arith_i,        // arithmetic op
  output logic                    freeze_bit_o,    // freeze state
  output logic                    restart_o,       // reissue captured access
  output logic                    range_trap_o,    // out-of-range trap pulse
  output logic                    fp_trap_o,       // fp exception trap pulse
  output logic                    dest_write_o,    // write result to dest
  output logic      [31:0]        result_o,        // add/sub result
  output logic      [31:0]        trap_instr_addr_reg_o // trapping address
);
  logic [31:0] access_address_capture;
  logic [31:0] access_data_capture;
  logic [31:0] access_control_capture;
  logic        freeze_bit;
  logic        div_overflow_mask;
  logic [4:0]  fp_mask;
  logic [4:0]  fp_trap_status;
  logic        flag_v;
  logic        flag_c;
  logic        ack;
  logic        bus_req;
  logic        bus_wr;
  logic [7:0]  idx;
  logic [31:0] wmask;
  logic [32:0] sum;
  logic        ovf_s;
  logic        carry_out;
  logic        range_hit;
  logic        is_addsub;
  logic        is_sub;
  logic [4:0]  fp_unmasked;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack;
  // write lands on the edge that shows ack, while the master still holds the request
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack;
  assign idx     = wb_adr_i[9:2];
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req;
    end
  end
  assign wb_ack_o = ack;

  // freeze set on trap wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freeze_bit <= 1'b0;
    end else if (trap_take_i) begin
      freeze_bit <= 1'b1;
    end else if (bus_wr && idx == aec_pkg::STAT_IDX && wb_sel_i[0]) begin
      freeze_bit <= wb_dat_i[0];
    end
  end
  assign freeze_bit_o = freeze_bit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_overflow_mask <= 1'b0;
      fp_mask           <= aec_pkg::FP_MASK_RST;
    end else if (bus_wr && idx == aec_pkg::ENV_IDX && wb_sel_i[0]) begin
      div_overflow_mask <= wb_dat_i[0];
      fp_mask           <= wb_dat_i[5:1];
    end
  end

  // capture refresh; hardware capture wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_address_capture <= aec_pkg::ZERO32;
    end else if (acc_i.valid && !freeze_bit) begin
      access_address_capture <= acc_i.addr;
    end else if (bus_wr && idx == aec_pkg::ADDR_IDX) begin
      access_address_capture <= (access_address_capture & ~wmask) | (wb_dat_i & wmask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_data_capture <= aec_pkg::ZERO32;
    end else if (acc_i.valid && !freeze_bit) begin
      // load data is left as whatever the port carries
      access_data_capture <= acc_i.data;
    end else if (bus_wr && idx == aec_pkg::DATA_IDX) begin
      access_data_capture <= (access_data_capture & ~wmask) | (wb_dat_i & wmask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_control_capture <= aec_pkg::ZERO32;
    end else if (acc_i.valid && !freeze_bit) begin
      access_control_capture <= {acc_i.instr_hi,
                                 acc_i.remaining,
                                 acc_i.is_load,
                                 acc_i.multi,
                                 acc_i.load_set,
                                 3'b000,
                                 acc_i.reg_num,
                                 1'b0,
                                 1'b1};
    end else if (target_write_i && !freeze_bit && access_control_capture[aec_pkg::CTRL_VALID_BIT]
                 && access_control_capture[aec_pkg::CTRL_LOAD_BIT]
                 && access_control_capture[9:2] == target_reg_i) begin
      access_control_capture[aec_pkg::CTRL_DISCARD_BIT] <= 1'b1;
    end else if (bus_wr && idx == aec_pkg::CTRL_IDX) begin
      access_control_capture <= (access_control_capture & ~(wmask & aec_pkg::CTRL_WMASK))
                              | (wb_dat_i & wmask & aec_pkg::CTRL_WMASK);
    end
  end

  // restart needs valid and not discarded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_o <= 1'b0;
    end else begin
      restart_o <= interrupt_return_i && access_control_capture[aec_pkg::CTRL_VALID_BIT]
                   && !access_control_capture[aec_pkg::CTRL_DISCARD_BIT];
    end
  end

  // arithmetic
  assign is_addsub = arith_i.op inside {aec_pkg::AOP_ADD_S, aec_pkg::AOP_ADD_U,
                                        aec_pkg::AOP_SUB_S, aec_pkg::AOP_SUB_U};
  assign is_sub    = arith_i.op inside {aec_pkg::AOP_SUB_S, aec_pkg::AOP_SUB_U};
  // subtract as a + ~b + cin, carry one means no borrow
  assign sum       = {1'b0, arith_i.a} + {1'b0, (is_sub ? ~arith_i.b : arith_i.b)}
                   + {32'h0000_0000, arith_i.carry_in};
  assign carry_out = sum[32];
  assign ovf_s     = (arith_i.a[31] == (is_sub ? ~arith_i.b[31] : arith_i.b[31]))
                   && (sum[31] != arith_i.a[31]);
  assign fp_unmasked = arith_i.fp_exc & ~fp_mask;

  always_comb begin
    range_hit = 1'b0;
    unique case (arith_i.op)
      aec_pkg::AOP_ADD_S, aec_pkg::AOP_SUB_S: range_hit = ovf_s;
      aec_pkg::AOP_ADD_U: range_hit = carry_out;
      aec_pkg::AOP_SUB_U: range_hit = !carry_out;
      aec_pkg::AOP_MUL:   range_hit = arith_i.mul_ovf;
      aec_pkg::AOP_DIV_S, aec_pkg::AOP_DIV_U:
        range_hit = (arith_i.divisor == aec_pkg::ZERO32)
                  || (arith_i.div_ovf && !div_overflow_mask);
      aec_pkg::AOP_FP:    range_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      range_trap_o <= 1'b0;
      fp_trap_o    <= 1'b0;
      dest_write_o <= 1'b0;
      result_o     <= aec_pkg::ZERO32;
    end else begin
      range_trap_o <= arith_i.valid && range_hit;
      fp_trap_o    <= arith_i.valid && arith_i.op == aec_pkg::AOP_FP && |fp_unmasked;
      // add/sub write even when trapping; mul/div/fp suppress on trap
      dest_write_o <= arith_i.valid && (is_addsub || !range_hit)
                      && !(arith_i.op == aec_pkg::AOP_FP && |fp_unmasked);
      if (arith_i.valid && is_addsub) begin
        result_o <= sum[31:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_instr_addr_reg_o <= aec_pkg::ZERO32;
    end else if (arith_i.valid && (range_hit || (arith_i.op == aec_pkg::AOP_FP && |fp_unmasked))) begin
      trap_instr_addr_reg_o <= instr_addr_i;
    end
  end

  // alu flags from every valid add/sub, trapping or not; multiply leaves them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_v <= 1'b0;
      flag_c <= 1'b0;
    end else if (arith_i.valid && is_addsub) begin
      flag_v <= ovf_s;
      flag_c <= carry_out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_trap_status <= 5'h00;
    end else if (arith_i.valid && arith_i.op == aec_pkg::AOP_FP && |fp_unmasked) begin
      fp_trap_status <= arith_i.fp_exc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= aec_pkg::ZERO32;
    end else if (bus_req && !wb_we_i) begin
      unique case (idx)
        aec_pkg::ADDR_IDX: wb_dat_o <= access_address_capture;
        aec_pkg::DATA_IDX: wb_dat_o <= access_data_capture;
        aec_pkg::CTRL_IDX: wb_dat_o <= access_control_capture;
        aec_pkg::STAT_IDX: wb_dat_o <= {20'h0_0000, fp_trap_status, flag_c, flag_v, 4'h0, freeze_bit};
        aec_pkg::ENV_IDX:  wb_dat_o <= {26'h000_0000, fp_mask, div_overflow_mask};
        default:           wb_dat_o <= aec_pkg::ZERO32;
      endcase
    end
  end

  // assertions on the capture registers
  property p_frozen_hold;
    @(posedge clk_i) disable iff (rst_i)
      freeze_bit && !(bus_wr && idx == aec_pkg::ADDR_IDX) |=> $stable(access_address_capture);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("address changed while frozen");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      acc_i.valid && !freeze_bit |=> access_address_capture == $past(acc_i.addr)
        && access_control_capture[aec_pkg::CTRL_VALID_BIT];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_store_data;
    @(posedge clk_i) disable iff (rst_i)
      acc_i.valid && !acc_i.is_load && !freeze_bit |=> access_data_capture == $past(acc_i.data);
  endproperty
  a_store_data: assert property (p_store_data) else $error("store data not captured");

  property p_ctrl_fields;
    @(posedge clk_i) disable iff (rst_i)
      acc_i.valid && !freeze_bit |=>
        access_control_capture[31:16] == {$past(acc_i.instr_hi), $past(acc_i.remaining)}
        && access_control_capture[aec_pkg::CTRL_LOAD_BIT] == $past(acc_i.is_load);
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields not captured");

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
      access_control_capture[12:10] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_discard;
    @(posedge clk_i) disable iff (rst_i)
      target_write_i && !freeze_bit && !acc_i.valid && access_control_capture[aec_pkg::CTRL_VALID_BIT]
        && access_control_capture[aec_pkg::CTRL_LOAD_BIT] && access_control_capture[9:2] == target_reg_i
        |=> access_control_capture[aec_pkg::CTRL_DISCARD_BIT];
  endproperty
  a_discard: assert property (p_discard) else $error("discard bit not set");

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
      restart_o |-> $past(access_control_capture[aec_pkg::CTRL_VALID_BIT])
        && !$past(access_control_capture[aec_pkg::CTRL_DISCARD_BIT]);
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart");

  property p_reissue;
    @(posedge clk_i) disable iff (rst_i)
      interrupt_return_i && access_control_capture[aec_pkg::CTRL_VALID_BIT]
        && !access_control_capture[aec_pkg::CTRL_DISCARD_BIT] |=> restart_o;
  endproperty
  a_reissue: assert property (p_reissue) else $error("restart missing");

  // assertions on the arithmetic traps
  property p_add_signed;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_ADD_S && arith_i.a[31] == arith_i.b[31]
        && sum[31] != arith_i.a[31] |=> range_trap_o && dest_write_o && flag_v;
  endproperty
  a_add_signed: assert property (p_add_signed) else $error("signed add overflow");

  property p_addu;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_ADD_U && carry_out
        |=> range_trap_o && dest_write_o && flag_c;
  endproperty
  a_addu: assert property (p_addu) else $error("unsigned add overflow");

  property p_subu;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_SUB_U && !carry_out
        |=> range_trap_o && dest_write_o && !flag_c;
  endproperty
  a_subu: assert property (p_subu) else $error("unsigned sub underflow");

  property p_zero_div;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op inside {aec_pkg::AOP_DIV_S, aec_pkg::AOP_DIV_U}
        && arith_i.divisor == aec_pkg::ZERO32 |=> range_trap_o && !dest_write_o;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("zero divide not trapped");

  property p_div_masked;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op inside {aec_pkg::AOP_DIV_S, aec_pkg::AOP_DIV_U}
        && arith_i.divisor != aec_pkg::ZERO32 && div_overflow_mask |=> !range_trap_o;
  endproperty
  a_div_masked: assert property (p_div_masked) else $error("masked divide trapped");

  property p_mul_trap;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_MUL && arith_i.mul_ovf |=> range_trap_o && !dest_write_o;
  endproperty
  a_mul_trap: assert property (p_mul_trap) else $error("multiply trap wrote destination");

  property p_mul;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_MUL |=> $stable(flag_v) && $stable(flag_c);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply touched flags");

  property p_trap_addr;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && range_hit |=> trap_instr_addr_reg_o == $past(instr_addr_i);
  endproperty
  a_trap_addr: assert property (p_trap_addr) else $error("trap address not kept");

  property p_fp_masked;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_FP && fp_unmasked == 5'h00 |=> !fp_trap_o && dest_write_o;
  endproperty
  a_fp_masked: assert property (p_fp_masked) else $error("masked fp exception trapped");

  property p_fp_status;
    @(posedge clk_i) disable iff (rst_i)
      arith_i.valid && arith_i.op == aec_pkg::AOP_FP && fp_unmasked != 5'h00
        |=> fp_trap_o && fp_trap_status == $past(arith_i.fp_exc);
  endproperty
  a_fp_status: assert property (p_fp_status) else $error("fp trap status not written");

  property p_fp;
    @(posedge clk_i) disable iff (rst_i)
      fp_trap_o |-> !dest_write_o;
  endproperty
  a_fp: assert property (p_fp) else $error("fp trap wrote destination");

  c_capture: cover property (@(posedge clk_i) acc_i.valid && !freeze_bit);
  c_discard: cover property (@(posedge clk_i) access_control_capture[aec_pkg::CTRL_DISCARD_BIT]);
  c_restart: cover property (@(posedge clk_i) restart_o);
  c_range:   cover property (@(posedge clk_i) range_trap_o);
  c_fp:      cover property (@(posedge clk_i) fp_trap_o);
endmodule
`default_nettype wire

// *** core/aec_pkg.sv ***
// package for the access exception capture block
package aec_pkg;
  localparam logic [7:0] ADDR_IDX         = 8'h04;
  localparam logic [7:0] DATA_IDX         = 8'h05;
  localparam logic [7:0] CTRL_IDX         = 8'h06;
  localparam logic [7:0] STAT_IDX         = 8'h07;
  localparam logic [7:0] ENV_IDX          = 8'h08;
  localparam int         CTRL_TOP_LSB     = 24;
  localparam int         CTRL_CNT_LSB     = 16;
  localparam int         CTRL_LOAD_BIT    = 15;
  localparam int         CTRL_MULTI_BIT   = 14;
  localparam int         CTRL_SET_BIT     = 13;
  localparam int         CTRL_REG_LSB     = 2;
  localparam int         CTRL_DISCARD_BIT = 1;
  localparam int         CTRL_VALID_BIT   = 0;
  localparam logic [31:0] CTRL_WMASK      = 32'hFFFF_E3FF;
  localparam logic [31:0] ZERO32          = 32'h0000_0000;
  localparam logic [4:0]  FP_MASK_RST     = 5'h1F;

  typedef enum logic [2:0] {
    AOP_ADD_S, AOP_ADD_U, AOP_SUB_S, AOP_SUB_U, AOP_MUL, AOP_DIV_S, AOP_DIV_U, AOP_FP
  } aec_op_t;

  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic        multi;
    logic        load_set;
    logic [7:0]  instr_hi;
    logic [7:0]  remaining;
    logic [7:0]  reg_num;
    logic [31:0] addr;
    logic [31:0] data;
  } aec_access_t;

  typedef struct packed {
    logic        valid;
    aec_op_t     op;
    logic [31:0] a;
    logic [31:0] b;
    logic        carry_in;
    logic [31:0] divisor;
    logic        div_ovf;
    logic        mul_ovf;
    logic [4:0]  fp_exc;
  } aec_arith_t;
endpackage

// *** tb/access_exception_capture_tb.sv ***
// self-checking bench for the access capture and trap block
`timescale 1ns/1ps
`default_nettype none
module access_exception_capture_tb;
  logic                 clk_i, rst_i, cyc, stb, we, trap_take, tw, interrupt_return;
  logic [31:0]          adr, wdat, rdat;
  logic [7:0]           treg;
  aec_pkg::aec_arith_t  ar;
  aec_pkg::aec_access_t a;
  wire aec_pkg::aec_access_t acc;
  wire logic [31:0]     dat_o, res, taddr;
  wire logic            ack, frz, restart, rt, ft, dw;
  int                   fail_count, total_checks;

  aec_access_src u_src (.clk_i(clk_i), .acc_o(acc));
  aec_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF), .wb_ack_o(ack), .acc_i(acc),
    .trap_take_i(trap_take), .target_write_i(tw), .target_reg_i(treg), .interrupt_return_i(interrupt_return),
    .instr_addr_i(32'h0000_4A40), .arith_i(ar), .freeze_bit_o(frz), .restart_o(restart),
    .range_trap_o(rt), .fp_trap_o(ft), .dest_write_o(dw), .result_o(res), .trap_instr_addr_reg_o(taddr));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until ack is sampled high at a rising edge, released at that same edge
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {24'h00_0000, ad};
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input string n, input logic [31:0] e);
    bus(1'b0, ad, 32'h0000_0000);
    chk(n, e, rdat);
  endtask
  task automatic tick;
    @(posedge clk_i);
    trap_take <= 1'b0;
    tw        <= 1'b0;
    interrupt_return      <= 1'b0;
    ar.valid  <= 1'b0;
    #1;
  endtask
  task automatic ret(input logic e);
    @(posedge clk_i);
    interrupt_return <= 1'b1;
    tick;
    chk("restart", 32'(e), 32'(restart));
  endtask
  task automatic hit(input logic [7:0] r);
    @(posedge clk_i);
    tw   <= 1'b1;
    treg <= r;
    tick;
  endtask
  // e is {range trap, fp trap, dest write}; subtracts carry in one, meaning no borrow
  task automatic arith(input aec_pkg::aec_op_t op, input logic [31:0] x, input logic [31:0] y,
                       input logic [31:0] dv, input logic [6:0] fl, input logic [2:0] e);
    @(posedge clk_i);
    ar <= {1'b1, op, x, y, 1'(op inside {aec_pkg::AOP_SUB_S, aec_pkg::AOP_SUB_U}), dv, fl};
    tick;
    chk("range_trap", 32'(e[2]), 32'(rt));
    chk("fp_trap", 32'(e[1]), 32'(ft));
    chk("dest_write", 32'(e[0]), 32'(dw));
  endtask
  function automatic logic [31:0] ctl(input aec_pkg::aec_access_t x);
    return {x.instr_hi, x.remaining, x.is_load, x.multi, x.load_set, 3'h0, x.reg_num, 1'b0, 1'b1};
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
  initial begin
    {cyc, stb, we, trap_take, tw, interrupt_return} = '0;
    {adr, wdat, treg} = '0;
    ar    = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h18, "ctrl", 32'h0000_0000);
    rd(8'h20, "env", 32'h0000_003E);
    rd(8'h3C, "unmapped", 32'h0000_0000);
    a = '{valid:1'b1, is_load:1'b0, multi:1'b1, load_set:1'b1, instr_hi:8'hA5, remaining:8'h1C,
          reg_num:8'h83, addr:32'h8000_1234, data:32'hDEAD_BEEF};
    u_src.issue(a);
    rd(8'h10, "addr", a.addr);
    rd(8'h14, "data", a.data);
    rd(8'h18, "ctrl", ctl(a));
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd(8'h18, "ctrl", 32'hFFFF_E3FF);
    ret(1'b0);
    bus(1'b1, 8'h18, 32'h0000_0001);
    ret(1'b1);
    a = '{valid:1'b1, is_load:1'b1, multi:1'b0, load_set:1'b0, instr_hi:8'h3C, remaining:8'h00,
          reg_num:8'h40, addr:32'h0000_0BA0, data:32'h0000_0000};
    u_src.issue(a);
    hit(8'h41);
    rd(8'h18, "ctrl", ctl(a));
    hit(8'h40);
    rd(8'h18, "ctrl", ctl(a) | 32'h0000_0002);
    ret(1'b0);
    @(posedge clk_i);
    trap_take <= 1'b1;
    tick;
    chk("freeze", 32'h0000_0001, 32'(frz));
    u_src.issue('{valid:1'b1, addr:32'h0000_5550, default:'0});
    rd(8'h10, "addr", a.addr);
    bus(1'b1, 8'h1C, 32'h0000_0000);
    u_src.issue('{valid:1'b1, addr:32'h0000_5550, default:'0});
    rd(8'h10, "addr", 32'h0000_5550);
    arith(aec_pkg::AOP_ADD_S, 32'h7FFF_FFFF, 32'h0000_0001, 32'h0000_0001, 7'h00, 3'b101);
    chk("result", 32'h8000_0000, res);
    chk("trap_addr", 32'h0000_4A40, taddr);
    rd(8'h1C, "status", 32'h0000_0020);
    arith(aec_pkg::AOP_ADD_S, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 7'h00, 3'b001);
    arith(aec_pkg::AOP_SUB_U, 32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 7'h00, 3'b101);
    chk("result", 32'hFFFF_FFFF, res);
    rd(8'h1C, "status", 32'h0000_0000);
    arith(aec_pkg::AOP_ADD_U, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0001, 7'h00, 3'b101);
    rd(8'h1C, "status", 32'h0000_0040);
    arith(aec_pkg::AOP_SUB_S, 32'h8000_0000, 32'h0000_0001, 32'h0000_0001, 7'h00, 3'b101);
    rd(8'h1C, "status", 32'h0000_0060);
    arith(aec_pkg::AOP_MUL, 32'h0001_0000, 32'h0001_0000, 32'h0000_0001, 7'h20, 3'b100);
    rd(8'h1C, "status", 32'h0000_0060);
    arith(aec_pkg::AOP_DIV_S, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_0001, 7'h40, 3'b100);
    bus(1'b1, 8'h20, 32'h0000_003F);
    arith(aec_pkg::AOP_DIV_U, 32'h0000_0005, 32'h0000_0001, 32'h0000_0001, 7'h40, 3'b001);
    arith(aec_pkg::AOP_DIV_U, 32'h0000_0005, 32'h0000_0000, 32'h0000_0000, 7'h00, 3'b100);
    arith(aec_pkg::AOP_FP, 32'h3F80_0000, 32'h0000_0000, 32'h0000_0001, 7'h04, 3'b001);
    bus(1'b1, 8'h20, 32'h0000_0004);
    arith(aec_pkg::AOP_FP, 32'h3F80_0000, 32'h0000_0000, 32'h0000_0001, 7'h02, 3'b001);
    arith(aec_pkg::AOP_FP, 32'h3F80_0000, 32'h0000_0000, 32'h0000_0001, 7'h06, 3'b010);
    bus(1'b0, 8'h1C, 32'h0000_0000);
    chk("fp_status", 32'h0000_0006, (rdat >> 7) & 32'h0000_001F);
    end_of_test;
  end
endmodule
`default_nettype wire

// *** tb/aec_access_src.sv ***
// access channel model that starts loads and stores
`timescale 1ns/1ps
`default_nettype none
module aec_access_src (
  input  wire logic                 clk_i, // processor clock
  output var  aec_pkg::aec_access_t acc_o  // access start, one cycle
);
  initial acc_o = '0;
  // after the start cycle valid clears and every other field flips, so a stale value can never pass for a capture
  task automatic issue(input aec_pkg::aec_access_t x);
    @(posedge clk_i);
    acc_o <= x;
    @(posedge clk_i);
    acc_o <= {1'b0, ~x[$bits(x)-2:0]};
  endtask
endmodule
`default_nettype wire
